// File: core/mpm_power_mode_ctrl.sv
// Operation
// RL1: Mode follows the supply feeding the rail
// RL2: Maskable main-supply restore wakes sleep to normal
// RL3: Maskable reset pin low wakes to battery
// RL4: Maskable midnight event wakes to battery
// RL5: Digital pin low or falling wakes
// RL6: Serial receive pin any edge wakes
// RL7: Alarm event wakes sleep to battery
// RL8: Main supply loss selects battery, ADCs off
// RL9: Firmware sleep request enters sleep
// RL10: Repeated sleep entries are honoured
// RL11: Battery to normal without interrupting execution
// RL12: Wake from sleep restarts core at vector
// RL13: Status bit 2 at 83h shows battery
// RL14: High bank indexed through FEh and FFh
// RL15: Low bank indexed through CEh and CFh
// RL16: ADC power-down fields power parts down
// RL17: PLL power-down bit 3, reset 0x01
// RL18: Retained bytes survive sleep
// RL19: Battery mode keeps core on, ADCs off
// RL20: Sleep turns regulators and core off
// RL21: Each maskable wake has its own mask
// RL22: Source flag synchronised, updates both ways; here it stays set if supply returns in sleep with restore masked
`timescale 1ns/1ps

module mpm_power_mode_ctrl (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rstn,
    // Special-function bus from the core
    input  wire mpm_pkg::mpm_sfr_s    sfr,
    output logic [7:0]                sfr_rdata,
    // Supply monitor: high while main supply is above threshold
    input  wire logic                 main_supply_ok,
    // Wake sources
    input  wire logic                 reset_pin_active_low,
    input  wire logic                 digital_io_wake_pin,
    input  wire logic                 serial_receive_wake_pin,
    input  wire logic                 rtc_midnight,
    input  wire logic                 rtc_alarm,
    input  wire logic [3:0]           wake_mask_en,
    // Firmware sleep request, one-cycle pulse from core logic
    input  wire logic                 sleep_request,
    // Mode and power controls
    output mpm_pkg::mpm_mode_e        mode,
    output logic                      rail_on_battery,
    output logic                      regulators_on,
    output logic                      core_restart,
    output logic                      adc_auto_off,
    output mpm_pkg::mpm_ana_pd_s      ana_pd
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Order: supply, reset pin, dio, rx, midnight, alarm
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;

    assign pin_raw = {rtc_alarm, rtc_midnight, serial_receive_wake_pin,
                      digital_io_wake_pin, reset_pin_active_low, main_supply_ok};
    // Idle levels: supply good matches the normal reset mode, rtc events low
    localparam logic [NSYNC-1:0] SYNC_RST = 6'h0F;

    // Wake logic sits on the always-powered clock
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[i] <= SYNC_RST[i];
                    sync2_ff[i] <= SYNC_RST[i];
                end else begin
                    sync1_ff[i] <= pin_raw[i];
                    sync2_ff[i] <= sync1_ff[i];
                end
            end
        end
    endgenerate

    logic supply_ok_s;
    logic resetpin_n_s;
    logic dio_s;
    logic rx_s;
    logic midnight_s;
    logic alarm_s;
    assign supply_ok_s  = sync2_ff[0];
    assign resetpin_n_s = sync2_ff[1];
    assign dio_s        = sync2_ff[2];
    assign rx_s         = sync2_ff[3];
    assign midnight_s   = sync2_ff[4];
    assign alarm_s      = sync2_ff[5];

    logic dio_d_ff;
    logic rx_d_ff;
    logic midnight_d_ff;
    logic alarm_d_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dio_d_ff      <= 1'b1;
            rx_d_ff       <= 1'b1;
            midnight_d_ff <= 1'b0;
            alarm_d_ff    <= 1'b0;
        end else begin
            dio_d_ff      <= dio_s;
            rx_d_ff       <= rx_s;
            midnight_d_ff <= midnight_s;
            alarm_d_ff    <= alarm_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake decode

    logic wake_restore;
    logic wake_battery;

    assign wake_restore = supply_ok_s && wake_mask_en[mpm_pkg::WMASK_RESTORE];   // RL2 RL21
    assign wake_battery =
        (!resetpin_n_s && wake_mask_en[mpm_pkg::WMASK_RESETPIN])                  // RL3 RL21
        || (midnight_s && !midnight_d_ff && wake_mask_en[mpm_pkg::WMASK_MIDNIGHT]) // RL4 RL21
        || !dio_s || (dio_d_ff && !dio_s)                                          // RL5
        || (rx_s ^ rx_d_ff)                                                        // RL6
        || (alarm_s && !alarm_d_ff);                                               // RL7

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine

    mpm_pkg::mpm_mode_e mode_ff;
    mpm_pkg::mpm_mode_e nxt_mode;
    logic               restart_ff;
    logic               nxt_restart;

    always_comb begin
        nxt_mode    = mode_ff;
        nxt_restart = 1'b0;
        unique case (mode_ff)
            mpm_pkg::MPM_NORMAL: begin
                if (!supply_ok_s) begin
                    nxt_mode = mpm_pkg::MPM_BATTERY;                              // RL8
                end
            end
            mpm_pkg::MPM_BATTERY: begin
                if (supply_ok_s) begin
                    nxt_mode = mpm_pkg::MPM_NORMAL;                               // RL11
                end else if (sleep_request) begin
                    nxt_mode = mpm_pkg::MPM_SLEEP;                                // RL9 RL10
                end
            end
            mpm_pkg::MPM_SLEEP: begin
                if (wake_restore) begin
                    nxt_mode    = mpm_pkg::MPM_NORMAL;                            // RL2
                    nxt_restart = 1'b1;                                           // RL12
                end else if (wake_battery) begin
                    nxt_mode    = mpm_pkg::MPM_BATTERY;
                    nxt_restart = 1'b1;                                           // RL12
                end
            end
            default: begin
                nxt_mode = mpm_pkg::MPM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff    <= mpm_pkg::MPM_NORMAL;
            restart_ff <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;                                               // RL1
            restart_ff <= nxt_restart;
        end
    end

    // Source flag from the mode, so it flips on every switchover except one met in sleep with the restore wake masked
    logic bat_src;
    assign bat_src = (mode_ff != mpm_pkg::MPM_NORMAL);                            // RL1 RL22

    ////////////////////////////////////////////////////////////////////////////
    // Indexed register banks

    logic [7:0] hv_idx_ff;
    logic [7:0] lv_idx_ff;
    logic [7:0] ret_ff [mpm_pkg::RET_COUNT];
    logic [7:0] pd_first_ff;
    logic [7:0] pd_second_ff;
    logic [7:0] pd_third_ff;
    logic [7:0] pll_ctl_ff;

    function automatic logic is_wr(input mpm_pkg::mpm_sfr_s s, input logic [7:0] a);
        is_wr = s.wr && (s.addr == a);
    endfunction : is_wr

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hv_idx_ff <= mpm_pkg::RST_IDX;
            lv_idx_ff <= mpm_pkg::RST_IDX;
        end else begin
            if (is_wr(sfr, mpm_pkg::SFR_HV_INDEX)) begin
                hv_idx_ff <= sfr.wdata;                                           // RL14
            end
            if (is_wr(sfr, mpm_pkg::SFR_LV_INDEX)) begin
                lv_idx_ff <= sfr.wdata;                                           // RL15
            end
        end
    end

    // Retained bytes reset only at power-on; sleep never touches them
    generate
        for (genvar r = 0; r < mpm_pkg::RET_COUNT; r++) begin : g_ret
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ret_ff[r] <= mpm_pkg::RST_RET;
                end else if (is_wr(sfr, mpm_pkg::SFR_HV_DATA)
                             && hv_idx_ff == mpm_pkg::IDX_RET_A + 8'(r)) begin
                    ret_ff[r] <= sfr.wdata;                                       // RL18
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pd_first_ff  <= mpm_pkg::RST_PD_FIRST;
            pd_second_ff <= mpm_pkg::RST_PD_SECOND;
            pd_third_ff  <= mpm_pkg::RST_PD_THIRD;
            pll_ctl_ff   <= mpm_pkg::RST_PLL_CTL;                                 // RL17
        end else if (is_wr(sfr, mpm_pkg::SFR_LV_DATA)) begin
            unique case (lv_idx_ff)
                mpm_pkg::IDX_PD_FIRST:  pd_first_ff  <= sfr.wdata;                // RL15 RL16
                mpm_pkg::IDX_PD_SECOND: pd_second_ff <= sfr.wdata;                // RL16
                mpm_pkg::IDX_PD_THIRD:  pd_third_ff  <= sfr.wdata;                // RL16
                mpm_pkg::IDX_PLL_CTL:   pll_ctl_ff   <= sfr.wdata;                // RL17
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] stat_val;

    always_comb begin
        stat_val = 8'h00;
        stat_val[mpm_pkg::BIT_BAT_SRC] = bat_src;                                 // RL13
        nxt_rdata = 8'h00;
        if (sfr.rd) begin
            unique case (sfr.addr)
                mpm_pkg::SFR_HV_INDEX: nxt_rdata = hv_idx_ff;
                mpm_pkg::SFR_LV_INDEX: nxt_rdata = lv_idx_ff;
                mpm_pkg::SFR_HV_DATA: begin
                    if (hv_idx_ff == mpm_pkg::IDX_PWR_STAT) begin
                        nxt_rdata = stat_val;                                     // RL13 RL14
                    end else if (hv_idx_ff >= mpm_pkg::IDX_RET_A
                                 && hv_idx_ff <= mpm_pkg::IDX_RET_E) begin
                        nxt_rdata = ret_ff[3'(hv_idx_ff - mpm_pkg::IDX_RET_A)];
                    end
                end
                mpm_pkg::SFR_LV_DATA: begin
                    unique case (lv_idx_ff)
                        mpm_pkg::IDX_PD_FIRST:  nxt_rdata = pd_first_ff;          // RL15
                        mpm_pkg::IDX_PD_SECOND: nxt_rdata = pd_second_ff;
                        mpm_pkg::IDX_PD_THIRD:  nxt_rdata = pd_third_ff;
                        mpm_pkg::IDX_PLL_CTL:   nxt_rdata = pll_ctl_ff;
                        default:                nxt_rdata = 8'h00;
                    endcase
                end
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    logic adc_off;
    assign adc_off = (mode_ff != mpm_pkg::MPM_NORMAL);                            // RL8 RL19

    assign sfr_rdata       = rdata_ff;
    assign mode            = mode_ff;
    assign rail_on_battery = bat_src;                                             // RL1
    assign regulators_on   = (mode_ff != mpm_pkg::MPM_SLEEP);                     // RL19 RL20
    assign core_restart    = restart_ff;                                          // RL12
    assign adc_auto_off    = adc_off;

    // Field bits or the automatic shutdown: ADCs off the main supply, PLL in sleep
    assign ana_pd.ref_pd                    = pd_first_ff[mpm_pkg::BIT_REF_PD] | adc_off;  // RL16
    assign ana_pd.first_current_channel_pd  = pd_first_ff[6:1] | {6{adc_off}};           // RL16
    assign ana_pd.second_current_channel_pd = {pd_first_ff[7], pd_second_ff[4:0]}
                                              | {6{adc_off}};                           // RL16
    assign ana_pd.voltage_channel_pd        = {pd_second_ff[7:5], pd_third_ff[2:0]}
                                              | {6{adc_off}};                           // RL16
    assign ana_pd.pll_pd = pll_ctl_ff[mpm_pkg::BIT_PLL_PD] | !regulators_on;              // RL17

endmodule : mpm_power_mode_ctrl

// File: pkg/mpm_pkg.sv
package mpm_pkg;

    // Special-function addresses of the two index/data port pairs
    localparam logic [7:0] SFR_HV_INDEX = 8'hFE;
    localparam logic [7:0] SFR_HV_DATA  = 8'hFF;
    localparam logic [7:0] SFR_LV_INDEX = 8'hCE;
    localparam logic [7:0] SFR_LV_DATA  = 8'hCF;

    // High-voltage bank indices
    localparam logic [7:0] IDX_RET_A    = 8'h27;
    localparam logic [7:0] IDX_RET_B    = 8'h28;
    localparam logic [7:0] IDX_RET_C    = 8'h29;
    localparam logic [7:0] IDX_RET_D    = 8'h2A;
    localparam logic [7:0] IDX_RET_E    = 8'h2B;
    localparam logic [7:0] IDX_PWR_STAT = 8'h83;

    // Low-voltage bank indices
    localparam logic [7:0] IDX_PD_FIRST  = 8'h2E;
    localparam logic [7:0] IDX_PD_SECOND = 8'h2F;
    localparam logic [7:0] IDX_PD_THIRD  = 8'h30;
    localparam logic [7:0] IDX_PLL_CTL   = 8'h31;

    // Reset values
    localparam logic [7:0] RST_RET       = 8'h00;
    localparam logic [7:0] RST_PD_FIRST  = 8'hFE;
    localparam logic [7:0] RST_PD_SECOND = 8'hFF;
    localparam logic [7:0] RST_PD_THIRD  = 8'h07;
    localparam logic [7:0] RST_PLL_CTL   = 8'h01;
    localparam logic [7:0] RST_IDX       = 8'h00;

    // Field positions
    localparam int BIT_BAT_SRC = 2;
    localparam int BIT_PLL_PD  = 3;
    localparam int BIT_REF_PD  = 0;

    // Wake mask bits (plain input vector)
    localparam int WMASK_RESTORE  = 0;
    localparam int WMASK_RESETPIN = 1;
    localparam int WMASK_MIDNIGHT = 2;
    localparam int WMASK_W        = 3;

    // Number of retained bytes
    localparam int RET_COUNT = 5;

    typedef enum logic [1:0] {
        MPM_NORMAL,
        MPM_BATTERY,
        MPM_SLEEP
    } mpm_mode_e;

    // Special-function bus access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mpm_sfr_s;

    // Analog power-down controls
    typedef struct packed {
        logic       ref_pd;
        logic [5:0] first_current_channel_pd;
        logic [5:0] second_current_channel_pd;
        logic [5:0] voltage_channel_pd;
        logic       pll_pd;
    } mpm_ana_pd_s;

endpackage : mpm_pkg

// File: test/mpm_fw_model.sv
`timescale 1ns/1ps

module mpm_fw_model (
    // Clock
    input  wire logic         clock,
    // Register bus toward the block
    output mpm_pkg::mpm_sfr_s sfr,
    input  wire logic [7:0]   sfr_rdata,
    // Core shutdown and supply monitor
    output logic              sleep_request,
    output logic              main_supply_ok
);
    initial begin
        sfr = '0;
        sleep_request = 1'b0;
        main_supply_ok = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released address and data are inverted so stale values never look valid
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        sfr = {w, !w, a, d};
        @(posedge clock);
        #1;
        sfr = {1'b0, 1'b0, ~a, ~d};
    endtask : bus

    task automatic wr_reg(input logic hv, input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, hv ? mpm_pkg::SFR_HV_INDEX : mpm_pkg::SFR_LV_INDEX, idx);
        bus(1'b1, hv ? mpm_pkg::SFR_HV_DATA : mpm_pkg::SFR_LV_DATA, d);
    endtask : wr_reg

    task automatic rd_reg(input logic hv, input logic [7:0] idx, output logic [7:0] d);
        bus(1'b1, hv ? mpm_pkg::SFR_HV_INDEX : mpm_pkg::SFR_LV_INDEX, idx);
        bus(1'b0, hv ? mpm_pkg::SFR_HV_DATA : mpm_pkg::SFR_LV_DATA, 8'h00);
        d = sfr_rdata;
    endtask : rd_reg

    task automatic sleep_now;
        @(posedge clock);
        #1;
        sleep_request = 1'b1;
        @(posedge clock);
        #1;
        sleep_request = 1'b0;
    endtask : sleep_now

    task automatic set_supply(input logic ok);
        @(posedge clock);
        #1;
        main_supply_ok = ok;
    endtask : set_supply
endmodule : mpm_fw_model

// File: test/mpm_pmc_assertions.sv
`timescale 1ns/1ps

module mpm_pmc_checker (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rstn,
    // Inputs of the block
    input wire logic                 main_supply_ok,
    input wire logic [3:0]           wake_mask_en,
    input wire logic                 sleep_request,
    // Outputs of the block
    input wire mpm_pkg::mpm_mode_e   mode,
    input wire logic                 rail_on_battery,
    input wire logic                 regulators_on,
    input wire logic                 core_restart,
    input wire logic                 adc_auto_off,
    input wire mpm_pkg::mpm_ana_pd_s ana_pd
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    a_flag_off_main: assert property (
        mode != mpm_pkg::MPM_NORMAL |-> ##[0:1] rail_on_battery)
        else $error("Source flag low off main supply");
    a_sleep_powers_off: assert property (
        mode == mpm_pkg::MPM_SLEEP |-> ##[0:1] !regulators_on)
        else $error("Regulators on in sleep");
    a_battery_adc_off: assert property (
        mode == mpm_pkg::MPM_BATTERY |-> ##[0:1] adc_auto_off && &{ana_pd.voltage_channel_pd,
        ana_pd.first_current_channel_pd, ana_pd.second_current_channel_pd})
        else $error("ADCs powered in battery mode");
    a_sleep_from_battery: assert property (
        $rose(mode == mpm_pkg::MPM_SLEEP) |-> $past(mode) == mpm_pkg::MPM_BATTERY)
        else $error("Sleep entered from wrong mode");
    a_sleep_on_request: assert property (
        !main_supply_ok [*3] ##0 (mode == mpm_pkg::MPM_BATTERY && sleep_request)
        |=> mode == mpm_pkg::MPM_SLEEP)
        else $error("Sleep request not honoured");
    a_wake_restarts: assert property (
        $fell(mode == mpm_pkg::MPM_SLEEP) |-> ##[0:1] core_restart)
        else $error("No core restart on wake");
    a_restart_single: assert property (
        core_restart |=> !core_restart)
        else $error("Core restart longer than one cycle");
    a_resume_no_restart: assert property (
        mode == mpm_pkg::MPM_BATTERY ##1 mode == mpm_pkg::MPM_NORMAL |-> !core_restart)
        else $error("Core restarted on battery to normal");
    a_loss_to_battery: assert property (
        (mode == mpm_pkg::MPM_NORMAL && $fell(main_supply_ok)) ##1 !main_supply_ok [*3]
        |-> mode == mpm_pkg::MPM_BATTERY)
        else $error("Supply loss did not select battery");
    a_restore_normal: assert property (
        (mode != mpm_pkg::MPM_NORMAL && (mode != mpm_pkg::MPM_SLEEP || wake_mask_en[0])
        && $rose(main_supply_ok)) ##1 main_supply_ok [*3] |-> mode == mpm_pkg::MPM_NORMAL)
        else $error("Supply restore did not select normal");

    c_sleep: cover property ($rose(mode == mpm_pkg::MPM_SLEEP));
    c_wake: cover property ($fell(mode == mpm_pkg::MPM_SLEEP));
    c_restart: cover property (core_restart);
endmodule : mpm_pmc_checker

bind mpm_power_mode_ctrl mpm_pmc_checker mpm_pmc_checker_inst (
    .clock(clock), .rstn(rstn), .main_supply_ok(main_supply_ok),
    .wake_mask_en(wake_mask_en), .sleep_request(sleep_request), .mode(mode),
    .rail_on_battery(rail_on_battery), .regulators_on(regulators_on),
    .core_restart(core_restart), .adc_auto_off(adc_auto_off), .ana_pd(ana_pd)
);

// File: test/test_meter_power_mode_controller.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module test_meter_power_mode_controller;
    logic                 clock = 1'b0;
    logic                 rstn = 1'b0;
    mpm_pkg::mpm_sfr_s    sfr;
    logic [7:0]           sfr_rdata;
    logic                 main_supply_ok, sleep_request;
    logic                 reset_pin_active_low = 1'b1;
    logic                 digital_io_wake_pin = 1'b1;
    logic                 serial_receive_wake_pin = 1'b1;
    logic                 rtc_midnight = 1'b0;
    logic                 rtc_alarm = 1'b0;
    logic [3:0]           wake_mask_en = 4'hF;
    mpm_pkg::mpm_mode_e   mode;
    logic                 rail_on_battery, regulators_on, core_restart, adc_auto_off;
    mpm_pkg::mpm_ana_pd_s ana_pd;
    int                   num_errors = 0;
    int                   n_checks = 0;
    int                   restarts = 0;
    logic [7:0]           v;

    always #25 clock = ~clock;
    always @(negedge clock) if (core_restart === 1'b1) restarts++;

    mpm_power_mode_ctrl mpm_power_mode_ctrl_inst (
        .clock(clock), .rstn(rstn), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .main_supply_ok(main_supply_ok), .reset_pin_active_low(reset_pin_active_low),
        .digital_io_wake_pin(digital_io_wake_pin),
        .serial_receive_wake_pin(serial_receive_wake_pin), .rtc_midnight(rtc_midnight),
        .rtc_alarm(rtc_alarm), .wake_mask_en(wake_mask_en), .sleep_request(sleep_request),
        .mode(mode), .rail_on_battery(rail_on_battery), .regulators_on(regulators_on),
        .core_restart(core_restart), .adc_auto_off(adc_auto_off), .ana_pd(ana_pd));

    mpm_fw_model mpm_fw_model_inst (
        .clock(clock), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .sleep_request(sleep_request), .main_supply_ok(main_supply_ok));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wait_mode(input mpm_pkg::mpm_mode_e m);
        for (int i = 0; i < 20 && mode !== m; i++) cyc(1);
    endtask : wait_mode

    task automatic enter_sleep;
        mpm_fw_model_inst.set_supply(1'b0);
        wait_mode(mpm_pkg::MPM_BATTERY);
        mpm_fw_model_inst.sleep_now();
        wait_mode(mpm_pkg::MPM_SLEEP);
    endtask : enter_sleep

    // Source 0 restore, 1 reset pin, 2 digital pin, 3 serial pin, 4 midnight, 5 alarm
    task automatic drive_src(input int s, input logic on);
        case (s)
            0: mpm_fw_model_inst.set_supply(on);
            1: reset_pin_active_low = !on;
            2: digital_io_wake_pin = !on;
            3: serial_receive_wake_pin = !on;
            4: rtc_midnight = on;
            default: rtc_alarm = on;
        endcase
    endtask : drive_src

    task automatic rd_chk(input logic hv, input logic [7:0] idx, output logic [7:0] d);
        mpm_fw_model_inst.rd_reg(hv, idx, d);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        logic [7:0] exp_lv [4] = '{8'hFE, 8'hFF, 8'h07, 8'h01};
        `CHK(mode, mpm_pkg::MPM_NORMAL)
        for (int i = 0; i < 5; i++) begin
            rd_chk(1'b1, mpm_pkg::IDX_RET_A + 8'(i), v);
            `CHK(v, 8'h00)
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk(1'b0, mpm_pkg::IDX_PD_FIRST + 8'(i), v);
            `CHK(v, exp_lv[i])
        end
        rd_chk(1'b1, mpm_pkg::IDX_PWR_STAT, v);
        `CHK(v, 8'h00)
        $display("test reset values done");
    endtask : test_reset_values

    task automatic test_registers;
        for (int i = 0; i < 5; i++) mpm_fw_model_inst.wr_reg(1'b1, 8'h27 + 8'(i), 8'hA0 + 8'(i));
        for (int i = 0; i < 5; i++) begin
            rd_chk(1'b1, 8'h27 + 8'(i), v);
            `CHK(v, 8'hA0 + 8'(i))
        end
        mpm_fw_model_inst.wr_reg(1'b1, mpm_pkg::IDX_PWR_STAT, 8'hFF);
        rd_chk(1'b1, mpm_pkg::IDX_PWR_STAT, v);
        `CHK(v, 8'h00)
        rd_chk(1'b1, mpm_pkg::IDX_PD_FIRST, v);
        `CHK(v, 8'h00)
        for (int i = 0; i < 4; i++) mpm_fw_model_inst.wr_reg(1'b0, 8'h2E + 8'(i), 8'h00);
        cyc(2);
        `CHK(ana_pd, 20'h00000)
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_FIRST, 8'h7E);
        cyc(2);
        `CHK(ana_pd, {1'b0, 6'h3F, 6'h00, 6'h00, 1'b0})
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_FIRST, 8'h81);
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_SECOND, 8'h1F);
        cyc(2);
        `CHK(ana_pd, {1'b1, 6'h00, 6'h3F, 6'h00, 1'b0})
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_FIRST, 8'h00);
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_SECOND, 8'hE0);
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PD_THIRD, 8'h07);
        mpm_fw_model_inst.wr_reg(1'b0, mpm_pkg::IDX_PLL_CTL, 8'h08);
        cyc(2);
        `CHK(ana_pd, {1'b0, 6'h00, 6'h00, 6'h3F, 1'b1})
        $display("test registers done");
    endtask : test_registers

    task automatic test_supply_switch;
        int r0;
        r0 = restarts;
        mpm_fw_model_inst.set_supply(1'b0);
        wait_mode(mpm_pkg::MPM_BATTERY);
        `CHK(mode, mpm_pkg::MPM_BATTERY)
        `CHK({rail_on_battery, adc_auto_off, regulators_on}, 3'b111)
        rd_chk(1'b1, mpm_pkg::IDX_PWR_STAT, v);
        `CHK(v, 8'h04)
        mpm_fw_model_inst.set_supply(1'b1);
        wait_mode(mpm_pkg::MPM_NORMAL);
        `CHK(mode, mpm_pkg::MPM_NORMAL)
        `CHK(restarts, r0)
        rd_chk(1'b1, mpm_pkg::IDX_PWR_STAT, v);
        `CHK(v, 8'h00)
        $display("test supply switch done");
    endtask : test_supply_switch

    task automatic test_wake_sources;
        int r0;
        for (int s = 1; s < 6; s++) begin
            mpm_fw_model_inst.wr_reg(1'b1, mpm_pkg::IDX_RET_A, 8'h50 + 8'(s));
            enter_sleep();
            `CHK({mode, regulators_on}, {mpm_pkg::MPM_SLEEP, 1'b0})
            r0 = restarts;
            drive_src(s, 1'b1);
            wait_mode(mpm_pkg::MPM_BATTERY);
            cyc(1);
            `CHK(mode, mpm_pkg::MPM_BATTERY)
            `CHK(restarts, r0 + 1)
            rd_chk(1'b1, mpm_pkg::IDX_RET_A, v);
            `CHK(v, 8'h50 + 8'(s))
            drive_src(s, 1'b0);
            cyc(4);
        end
        $display("test wake sources done");
    endtask : test_wake_sources

    task automatic test_masked_wakes;
        int s;
        for (int m = 0; m < 3; m++) begin
            s = (m == 2) ? 4 : m;
            enter_sleep();
            wake_mask_en = 4'hF ^ (4'h1 << m);
            drive_src(s, 1'b1);
            cyc(10);
            `CHK(mode, mpm_pkg::MPM_SLEEP)
            drive_src(s, 1'b0);
            cyc(4);
            drive_src(5, 1'b1);
            wait_mode(mpm_pkg::MPM_BATTERY);
            drive_src(5, 1'b0);
            wake_mask_en = 4'hF;
            cyc(4);
        end
        enter_sleep();
        s = restarts;
        mpm_fw_model_inst.set_supply(1'b1);
        wait_mode(mpm_pkg::MPM_NORMAL);
        cyc(1);
        `CHK(mode, mpm_pkg::MPM_NORMAL)
        `CHK(restarts, s + 1)
        $display("test masked wakes done");
    endtask : test_masked_wakes

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #2_000_000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(4);
        test_reset_values();
        test_registers();
        test_supply_switch();
        test_wake_sources();
        test_masked_wakes();
        report_and_stop();
    end
endmodule : test_meter_power_mode_controller
